// [verilog/rtc_pkg.sv]
// Constants for the real-time clock control and regulator enable block
`default_nettype none
package rtc_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CNT_W = 40;
    localparam int BYTE_W = 8;
    localparam int NUM_BYTES = 5;
    localparam int PRESC_W = 7;
    localparam int IDX_W = 3;

    // ------------------------------------------------------------------
    // Configuration mux addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_COUNTER_BASE = 8'h40;
    localparam logic [7:0] ADDR_MATCH_BASE = 8'h48;
    localparam logic [7:0] ADDR_MATCHBITS_BASE = 8'h50;
    localparam logic [7:0] ADDR_CLOCK_CONTROL_STATUS = 8'h58;
    localparam logic [7:0] ADDR_TEST = 8'h59;
    localparam logic [2:0] LAST_BYTE_IDX = 3'h4;

    // ------------------------------------------------------------------
    // Control/status bit positions
    // ------------------------------------------------------------------
    localparam int CSR_SOFT_RST = 7;
    localparam int CSR_CNT_EN = 6;
    localparam int CSR_REG_ON_MATCH = 5;
    localparam int CSR_OSC_MODE_HI = 4;
    localparam int CSR_OSC_MODE_LO = 3;
    localparam int CSR_CLR_ON_MATCH = 2;
    localparam int CSR_CNT_RUN = 1;
    localparam int CSR_OSC_SELECT = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Prescaler: divide by 128, first tick half way through
    // ------------------------------------------------------------------
    localparam logic [PRESC_W-1:0] PRESC_RESET = 7'h00;
    localparam logic [PRESC_W-1:0] PRESC_TICK = 7'h3F;
    localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;

    // ------------------------------------------------------------------
    // Regulator initialization
    // ------------------------------------------------------------------
    localparam logic [1:0] REG_INIT_ON = 2'h1;

    typedef enum logic [0:0] {
        INIT_WAIT,
        INIT_DONE
    } rtc_init_e;
endpackage : rtc_pkg
`default_nettype wire

// [verilog/rtc_reg_if.sv]
// Carrier between the clock core and the regulator enable logic
`timescale 1ns/10ps
`default_nettype none
interface rtc_reg_if;
    logic match;
    logic power_up_pin_n;
    logic [1:0] init_bits;
    logic off_cmd;
    logic reg_en;

    modport core (output match, output power_up_pin_n, output init_bits, output off_cmd, input reg_en);
    modport regulator (input match, input power_up_pin_n, input init_bits, input off_cmd, output reg_en);
endinterface : rtc_reg_if
`default_nettype wire

// [verilog/rtc_regulator.sv]
// Regulator initialization unit and sticky regulator enable
`timescale 1ns/10ps
`default_nettype none
module rtc_regulator
    import rtc_pkg::*;
(
    input wire logic i_clk_sys,       // Config mux clock
    input wire logic i_supply_rst,    // Supply-fail reset, active high
    rtc_reg_if.regulator bus          // Signals from the clock core
);
    rtc_init_e state_q;
    logic reg_en_q;
    logic init_on;
    logic set_req;

    // ------------------------------------------------------------------
    // Init bits are read once, on the first edge after supply reset
    // ------------------------------------------------------------------
    assign init_on = (state_q == INIT_WAIT) && (bus.init_bits == REG_INIT_ON);
    assign set_req = !bus.power_up_pin_n || bus.match || init_on;

    always_ff @(posedge i_clk_sys or posedge i_supply_rst) begin
        if (i_supply_rst) begin
            state_q <= INIT_WAIT;
        end else begin
            state_q <= INIT_DONE;
        end
    end

    // ------------------------------------------------------------------
    // Latch: set wins over the fabric clear; only supply fail resets it
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_supply_rst) begin
        if (i_supply_rst) begin
            reg_en_q <= 1'b0;
        end else if (set_req) begin
            reg_en_q <= 1'b1;
        end else if (bus.off_cmd) begin
            reg_en_q <= 1'b0;
        end
    end

    assign bus.reg_en = reg_en_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_reg_set;
        @(posedge i_clk_sys) disable iff (i_supply_rst)
        set_req |=> reg_en_q;
    endproperty
    a_reg_set: assert property (p_reg_set) else $error("regulator enable not set by source");

    property p_reg_hold;
        @(posedge i_clk_sys) disable iff (i_supply_rst)
        reg_en_q && !bus.off_cmd |=> reg_en_q;
    endproperty
    a_reg_hold: assert property (p_reg_hold) else $error("regulator enable dropped without command");

    property p_init_once;
        @(posedge i_clk_sys) disable iff (i_supply_rst)
        (state_q == INIT_WAIT) |=> (state_q == INIT_DONE) [*2];
    endproperty
    a_init_once: assert property (p_init_once) else $error("init unit did not finish");
endmodule : rtc_regulator
`default_nettype wire

// [verilog/rtc_core.sv]
// Real-time clock core: control/status register, prescaler, counter, match
// Behaviour
// - Writing one to control bit 7 puts the clock logic in reset.
// - Clock state except control register resets while supply bad or soft reset.
// - Reset releases two config clock edges after supply good and soft reset clear.
// - All control bits read zero whenever the supply is not good.
// - Bit 6 enables counting when the clock logic is out of reset.
// - Clearing bit 6 resets prescaler and stops counting, count kept.
// - First increment on 64th timebase edge, then every 128 edges.
// - Bit 5 lets counter/match equality drive match output, else low.
// - Bits 4:3 drive oscillator mode outputs; software uses 01 for crystal.
// - Bit 2 clears counter on next prescaled tick after a match.
// - Bit 1 at zero holds counter at zero, one permits counting.
// - Bit 0 drives oscillator select output choosing oscillator owner.
// - Timebase clock divided by 128 drives the counter.
// - Init unit reads two design bits at reset exit to start regulator.
// - Power-up pin, match or init unit set the sticky regulator enable.
// - Only fabric command clears regulator enable, except supply fail reset.
// - Counter and match register are five addressable bytes each.
// - Forty equality bits compare counter and match, readable as bytes.
`timescale 1ns/10ps
`default_nettype none
module rtc_core
    import rtc_pkg::*;
(
    input wire logic i_clk_sys,            // Config mux clock, 100 MHz
    input wire logic i_rst,                // Async reset, active high
    input wire logic i_supply_good_flag,   // Analog supply above threshold
    input wire logic i_timebase_clk_in,    // Oscillator clock, sampled
    input wire logic [7:0] i_mux_addr,     // Config mux address
    input wire logic i_mux_wen,            // Config mux write strobe
    input wire logic [7:0] i_mux_wdata,    // Config mux write data
    output logic [7:0] o_mux_rdata,        // Config mux read data
    input wire logic i_power_up_pin_n,     // Power-up pin, active low
    input wire logic [1:0] i_reg_init_bits,// Design-time regulator bits
    input wire logic i_reg_off_cmd,        // Fabric command to stop regulator
    output logic o_match_out,              // Gated counter/match equality
    output logic [1:0] o_osc_mode_out,     // Oscillator mode pins
    output logic o_osc_select_out,         // Oscillator ownership pin
    output logic o_reg_en                  // Regulator enable
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0] csr_q;
    logic supply_rst;
    logic raw_rst;
    logic rst_s1_q;
    logic rst_hold_q;
    logic tb_prev_q;
    logic tb_rise;
    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic tick;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] match_q;
    logic [CNT_W-1:0] match_bits;
    logic equal;
    logic [7:0] rdata_d;
    logic [IDX_W-1:0] byte_idx;
    logic idx_ok;
    logic sel_cnt;
    logic sel_match;
    logic sel_mbits;
    logic sel_csr;
    logic wr_cnt;
    logic wr_match;
    logic wr_csr;
    logic run;
    logic [7:0] cnt_b [NUM_BYTES];
    logic [7:0] match_b [NUM_BYTES];
    logic [7:0] mbits_b [NUM_BYTES];
    logic [CNT_W-1:0] cnt_wr_val;
    logic [CNT_W-1:0] match_wr_val;

    rtc_reg_if reg_bus ();

    // ------------------------------------------------------------------
    // Resets
    // ------------------------------------------------------------------
    assign supply_rst = i_rst || !i_supply_good_flag;
    assign raw_rst = supply_rst || csr_q[CSR_SOFT_RST];

    // Asserted at once, released after two config clock edges
    always_ff @(posedge i_clk_sys or posedge raw_rst) begin
        if (raw_rst) begin
            rst_s1_q <= 1'b1;
            rst_hold_q <= 1'b1;
        end else begin
            rst_s1_q <= 1'b0;
            rst_hold_q <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Control/status register, cleared only by supply fail
    // ------------------------------------------------------------------
    assign byte_idx = i_mux_addr[IDX_W-1:0];
    assign idx_ok = byte_idx <= LAST_BYTE_IDX;
    assign sel_cnt = (i_mux_addr[7:3] == ADDR_COUNTER_BASE[7:3]) && idx_ok;
    assign sel_match = (i_mux_addr[7:3] == ADDR_MATCH_BASE[7:3]) && idx_ok;
    assign sel_mbits = (i_mux_addr[7:3] == ADDR_MATCHBITS_BASE[7:3]) && idx_ok;
    assign sel_csr = i_mux_addr == ADDR_CLOCK_CONTROL_STATUS;
    assign wr_cnt = i_mux_wen && sel_cnt;
    assign wr_match = i_mux_wen && sel_match;
    assign wr_csr = i_mux_wen && sel_csr;

    always_ff @(posedge i_clk_sys or posedge supply_rst) begin
        if (supply_rst) begin
            csr_q <= CSR_RESET;
        end else if (wr_csr) begin
            csr_q <= i_mux_wdata;
        end
    end

    assign o_osc_mode_out = csr_q[CSR_OSC_MODE_HI:CSR_OSC_MODE_LO];
    assign o_osc_select_out = csr_q[CSR_OSC_SELECT];

    // ------------------------------------------------------------------
    // Prescaler on sampled timebase edges
    // ------------------------------------------------------------------
    assign run = csr_q[CSR_CNT_EN] && csr_q[CSR_CNT_RUN];
    assign tb_rise = i_timebase_clk_in && !tb_prev_q;
    // Divide by 128 with the tick half way, matching a 50% duty divider
    assign tick = run && tb_rise && (presc_q == PRESC_TICK);
    assign presc_d = !run ? PRESC_RESET : (tb_rise ? presc_q + 7'h01 : presc_q);

    always_ff @(posedge i_clk_sys or posedge rst_hold_q) begin
        if (rst_hold_q) begin
            tb_prev_q <= 1'b0;
            presc_q <= PRESC_RESET;
        end else begin
            tb_prev_q <= i_timebase_clk_in;
            presc_q <= presc_d;
        end
    end

    // ------------------------------------------------------------------
    // Byte views of counter, match register and equality bits
    // ------------------------------------------------------------------
    assign match_bits = ~(cnt_q ^ match_q);
    assign equal = &match_bits;

    genvar g;
    generate
        for (g = 0; g < NUM_BYTES; g++) begin : g_bytes
            assign cnt_b[g] = cnt_q[g*BYTE_W +: BYTE_W];
            assign match_b[g] = match_q[g*BYTE_W +: BYTE_W];
            assign mbits_b[g] = match_bits[g*BYTE_W +: BYTE_W];
            assign cnt_wr_val[g*BYTE_W +: BYTE_W] =
                (wr_cnt && byte_idx == g) ? i_mux_wdata : cnt_q[g*BYTE_W +: BYTE_W];
            assign match_wr_val[g*BYTE_W +: BYTE_W] =
                (wr_match && byte_idx == g) ? i_mux_wdata : match_q[g*BYTE_W +: BYTE_W];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    assign cnt_inc = cnt_q + CNT_ONE;

    // Byte writes while counting race the tick; fabric disables first
    always_comb begin
        if (!csr_q[CSR_CNT_RUN]) begin
            cnt_d = CNT_RESET;
        end else if (wr_cnt) begin
            cnt_d = cnt_wr_val;
        end else if (tick && csr_q[CSR_CLR_ON_MATCH] && equal) begin
            cnt_d = CNT_RESET;
        end else if (tick) begin
            cnt_d = cnt_inc;
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge i_clk_sys or posedge rst_hold_q) begin
        if (rst_hold_q) begin
            cnt_q <= CNT_RESET;
            match_q <= CNT_RESET;
        end else begin
            cnt_q <= cnt_d;
            match_q <= match_wr_val;
        end
    end

    assign o_match_out = csr_q[CSR_REG_ON_MATCH] && equal;

    // ------------------------------------------------------------------
    // Read path, registered
    // ------------------------------------------------------------------
    assign rdata_d = sel_cnt ? cnt_b[byte_idx] :
                     sel_match ? match_b[byte_idx] :
                     sel_mbits ? mbits_b[byte_idx] :
                     sel_csr ? csr_q : 8'h00;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_mux_rdata <= 8'h00;
        end else begin
            o_mux_rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Regulator enable
    // ------------------------------------------------------------------
    assign reg_bus.match = o_match_out;
    assign reg_bus.power_up_pin_n = i_power_up_pin_n;
    assign reg_bus.init_bits = i_reg_init_bits;
    assign reg_bus.off_cmd = i_reg_off_cmd;
    assign o_reg_en = reg_bus.reg_en;

    rtc_regulator u_regulator (
        .i_clk_sys(i_clk_sys),
        .i_supply_rst(supply_rst),
        .bus(reg_bus)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_soft_rst;
        @(posedge i_clk_sys) disable iff (i_rst)
        csr_q[CSR_SOFT_RST] |-> rst_hold_q && cnt_q == CNT_RESET;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset did not hold core");

    sequence s_rst_low3;
        $fell(raw_rst) ##1 !raw_rst ##1 !raw_rst;
    endsequence
    property p_rst_release;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_rst_low3 |-> !rst_hold_q && $past(rst_hold_q, 1);
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("reset release not two edges");

    property p_csr_default;
        @(posedge i_clk_sys)
        !i_supply_good_flag |-> csr_q == CSR_RESET;
    endproperty
    a_csr_default: assert property (p_csr_default) else $error("control bits not zero");

    property p_disabled_hold;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        !csr_q[CSR_CNT_EN] && !wr_cnt && !wr_csr |=> presc_q == PRESC_RESET && $stable(cnt_q);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("disabled counter moved");

    property p_first_tick;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        $changed(cnt_q) && $past(csr_q[CSR_CNT_RUN]) && !$past(wr_cnt)
            |-> $past(run && tb_rise && presc_q == PRESC_TICK);
    endproperty
    a_first_tick: assert property (p_first_tick) else $error("counter moved off the prescale tick");

    property p_presc_step;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        run && tb_rise |=> presc_q == $past(presc_q) + 7'h01;
    endproperty
    a_presc_step: assert property (p_presc_step) else $error("prescaler skipped an edge");

    property p_cnt_write;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        wr_cnt && csr_q[CSR_CNT_RUN] |=> cnt_b[$past(byte_idx)] == $past(i_mux_wdata);
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("counter byte write lost");

    property p_match_gate;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_match_out |-> csr_q[CSR_REG_ON_MATCH] && cnt_q == match_q;
    endproperty
    a_match_gate: assert property (p_match_gate) else $error("match output without cause");

    property p_osc_pins;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_csr |=> o_osc_mode_out == $past(i_mux_wdata[CSR_OSC_MODE_HI:CSR_OSC_MODE_LO])
            && o_osc_select_out == $past(i_mux_wdata[CSR_OSC_SELECT]);
    endproperty
    a_osc_pins: assert property (p_osc_pins) else $error("oscillator pins not from control");

    property p_clr_match;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        tick && csr_q[CSR_CLR_ON_MATCH] && equal && !wr_cnt |=> cnt_q == CNT_RESET;
    endproperty
    a_clr_match: assert property (p_clr_match) else $error("counter not cleared on match");

    property p_cnt_zero;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        !csr_q[CSR_CNT_RUN] |=> cnt_q == CNT_RESET;
    endproperty
    a_cnt_zero: assert property (p_cnt_zero) else $error("counter not held at zero");

    property p_inc;
        @(posedge i_clk_sys) disable iff (rst_hold_q)
        tick && !wr_cnt && !(csr_q[CSR_CLR_ON_MATCH] && equal) |=> cnt_q == $past(cnt_inc);
    endproperty
    a_inc: assert property (p_inc) else $error("counter did not advance by one");
endmodule : rtc_core
`default_nettype wire

// [bench/rtc_fabric_model.sv]
// Fabric-side writer and reader on the configuration mux port
`timescale 1ns/10ps
`default_nettype none
module rtc_fabric_model (
    input wire logic i_clk_sys,      // Config mux clock
    input wire logic [7:0] i_rdata,  // Read data from the block
    output logic [7:0] o_addr,       // Register address
    output logic o_wen,              // Write strobe
    output logic [7:0] o_wdata       // Write data
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    initial begin
        o_addr = 8'hFF;
        o_wen = 1'b0;
        o_wdata = 8'h00;
    end

    // Released lines show inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wen = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wen = 1'b0;
        o_wdata = ~d;
        o_addr = ~a;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        @(posedge i_clk_sys);
        #1;
        d = i_rdata;
        o_addr = ~a;
    endtask : rd
endmodule : rtc_fabric_model
`default_nettype wire

// [bench/tb_rtc_control_and_regulator_enable.sv]
// Self-checking testbench for the clock control and regulator enable block
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_control_and_regulator_enable
    import rtc_pkg::*;
();
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic supply_good = 1'b1;
    logic timebase_clk = 1'b0;
    logic power_up_pin_n = 1'b1;
    logic [1:0] reg_init_bits = 2'h1;
    logic reg_off_cmd = 1'b0;
    logic [7:0] mux_addr, mux_wdata, mux_rdata;
    logic mux_wen, match_out, osc_select_out, reg_en;
    logic [1:0] osc_mode_out;
    int bad_count = 0;
    int comparisons = 0;
    longint m_cnt = 0, m_mat = 0, c;
    int m_csr = 0, m_presc = 0;
    logic [7:0] b;

    always #5 clk_sys = ~clk_sys;

    rtc_core u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_supply_good_flag(supply_good),
        .i_timebase_clk_in(timebase_clk), .i_mux_addr(mux_addr), .i_mux_wen(mux_wen),
        .i_mux_wdata(mux_wdata), .o_mux_rdata(mux_rdata), .i_power_up_pin_n(power_up_pin_n),
        .i_reg_init_bits(reg_init_bits), .i_reg_off_cmd(reg_off_cmd), .o_match_out(match_out),
        .o_osc_mode_out(osc_mode_out), .o_osc_select_out(osc_select_out), .o_reg_en(reg_en));
    rtc_fabric_model u_fab (.i_clk_sys(clk_sys), .i_rdata(mux_rdata), .o_addr(mux_addr),
        .o_wen(mux_wen), .o_wdata(mux_wdata));

    // ------------------------------------------------------------
    // Model and helpers
    // ------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic longint put(longint v, int i, logic [7:0] d);
        return (v & ~(64'hFF << (8 * i))) | (longint'(d) << (8 * i));
    endfunction : put

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        u_fab.wr(a, d);
        if (a == ADDR_CLOCK_CONTROL_STATUS) begin
            m_csr = d;
            if (!d[CSR_CNT_EN] || d[CSR_SOFT_RST]) m_presc = 0;
            if (d[CSR_SOFT_RST]) m_mat = 0;
            if (d[CSR_SOFT_RST] || !d[CSR_CNT_RUN]) m_cnt = 0;
        end
        if (a[7:3] == 5'h08 && a[2:0] <= LAST_BYTE_IDX && m_csr[1] && !m_csr[7]) m_cnt = put(m_cnt, a[2:0], d);
        if (a[7:3] == 5'h09 && a[2:0] <= LAST_BYTE_IDX && !m_csr[7]) m_mat = put(m_mat, a[2:0], d);
    endtask : w

    task automatic load(input logic [7:0] base, input longint v);
        for (int i = 0; i < NUM_BYTES; i++) w(base + 8'(i), 8'(v >> (8 * i)));
    endtask : load

    task automatic rd40(input logic [7:0] base, output logic [39:0] v);
        for (int i = 0; i < NUM_BYTES; i++) begin
            u_fab.rd(base + 8'(i), b);
            v[8*i +: 8] = b;
        end
    endtask : rd40

    task automatic chk_all();
        logic [39:0] v;
        rd40(ADDR_COUNTER_BASE, v);
        chk("counter", 40'(m_cnt), v);
        rd40(ADDR_MATCH_BASE, v);
        chk("match", 40'(m_mat), v);
        rd40(ADDR_MATCHBITS_BASE, v);
        chk("match bits", ~40'(m_cnt ^ m_mat), v);
        u_fab.rd(ADDR_CLOCK_CONTROL_STATUS, b);
        chk("control", 40'(m_csr), 40'(b));
    endtask : chk_all

    // Each timebase edge is held two cycles high and two low for the sampler
    task automatic edges(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            #1;
            timebase_clk = 1'b1;
            if (m_csr[6] && m_csr[1] && !m_csr[7]) begin
                if (m_presc == 63) m_cnt = (m_csr[2] && m_cnt == m_mat) ? 0 : (m_cnt + 1) & 64'hFF_FFFF_FFFF;
                m_presc = (m_presc + 1) % 128;
            end
            repeat (2) @(posedge clk_sys);
            #1;
            timebase_clk = 1'b0;
            @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
    endtask : edges

    task automatic off_pulse();
        @(posedge clk_sys);
        #1;
        reg_off_cmd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_off_cmd = 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : off_pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        #500000;
        bad_count++;
        test_done();
    end

    initial begin
        void'($urandom(71880));
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("reg enable", 40'h1, 40'(reg_en));
        chk_all();
        off_pulse();
        chk("reg enable", 40'h0, 40'(reg_en));
        #1;
        power_up_pin_n = 1'b0;
        @(posedge clk_sys);
        #1;
        power_up_pin_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("reg enable", 40'h1, 40'(reg_en));
        off_pulse();
        for (int m = 0; m < 4; m++) begin
            w(ADDR_CLOCK_CONTROL_STATUS, 8'(m * 8 + m % 2));
            chk("osc mode", 40'(m), 40'(osc_mode_out));
            chk("osc select", 40'(m % 2), 40'(osc_select_out));
        end
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h2B);
        c = ((longint'($urandom) << 8) ^ longint'($urandom)) & 64'h7F_FFFF_FFFF;
        load(ADDR_COUNTER_BASE, c);
        load(ADDR_MATCH_BASE, c + 1);
        chk_all();
        chk("match out", 40'h0, 40'(match_out));
        off_pulse();
        chk("reg enable", 40'h0, 40'(reg_en));
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h6B);
        edges(63);
        chk_all();
        edges(1);
        chk_all();
        chk("match out", 40'h1, 40'(match_out));
        chk("reg enable", 40'h1, 40'(reg_en));
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h4B);
        chk("match out", 40'h0, 40'(match_out));
        edges(128);
        chk_all();
        edges(30);
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h2F);
        chk_all();
        load(ADDR_MATCH_BASE, m_cnt + 1);
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h6F);
        edges(63);
        chk_all();
        edges(1);
        chk("match out", 40'h1, 40'(match_out));
        edges(128);
        chk_all();
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h2B);
        load(ADDR_COUNTER_BASE, 64'hFF_FFFF_FFFF);
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h6B);
        edges(64);
        chk_all();
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h29);
        w(ADDR_COUNTER_BASE, 8'h5A);
        chk_all();
        u_fab.rd(ADDR_TEST, b);
        chk("test reg", 40'h0, 40'(b));
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h2B);
        load(ADDR_COUNTER_BASE, c);
        load(ADDR_MATCH_BASE, c);
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h80);
        w(ADDR_COUNTER_BASE, 8'h11);
        chk_all();
        w(ADDR_CLOCK_CONTROL_STATUS, 8'h2B);
        repeat (2) @(posedge clk_sys);
        w(ADDR_COUNTER_BASE, 8'h33);
        chk_all();
        reg_init_bits = 2'h0;
        supply_good = 1'b0;
        m_csr = 0;
        m_cnt = 0;
        m_mat = 0;
        repeat (2) @(posedge clk_sys);
        chk("osc mode", 40'h0, 40'(osc_mode_out));
        chk("reg enable", 40'h0, 40'(reg_en));
        #1;
        supply_good = 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_all();
        chk("reg enable", 40'h0, 40'(reg_en));
        test_done();
    end
endmodule : tb_rtc_control_and_regulator_enable
`default_nettype wire
